/* inc/cable_diag_cfg.svh */
// Offsets, field positions and reset values of the cable diagnostic bank.
`ifndef CABLE_DIAG_CFG_SVH
`define CABLE_DIAG_CFG_SVH

// Extended register addresses as seen by the management interface.
`define AMP3_ADDR 16'h0187
`define AMP4_ADDR 16'h0188
`define AMP5_ADDR 16'h0189
`define GENERAL_ADDR 16'h018a
`define GAIN_ADDR 16'h0215
`define ACCUM_ADDR 16'h021d

// Field positions inside a 16-bit register word.
`define AMP_HI_MSB 14
`define AMP_HI_LSB 8
`define AMP_LO_MSB 6
`define AMP_LO_LSB 0
`define TX_POL_LSB 11
`define RX_POL_LSB 6
`define TX_CROSS_BIT 5
`define RX_CROSS_BIT 4
`define TX_MANY_BIT 3
`define RX_MANY_BIT 2

// Field widths.
`define AMP_W 7
`define PEAKS 5
`define GAIN_W 4
`define ACCUM_W 12

// Reset values.
`define RESULT_RST 16'h0000
`define GAIN_RST 4'h3
`define ACCUM_RST 12'h600

`endif

/* inc/cable_diag_pkg.sv */
// Types shared by the cable diagnostic result bank.
package cable_diag_pkg;

    // One complete result set delivered by the reflectometry engine.
    // Index 0 of each array is the first peak, index 4 the fifth.
    typedef struct packed {
        logic [4:0][6:0] rx_amp;
        logic [6:0] tx_amp5;
        logic [4:0] tx_pol;
        logic [4:0] rx_pol;
        logic tx_cross;
        logic rx_cross;
        logic tx_many;
        logic rx_many;
    } diag_result_s;

    // Register access request from the management interface.
    typedef struct packed {
        logic [15:0] addr;
        logic wr;
        logic rd;
        logic [15:0] wdata;
    } reg_req_s;

endpackage : cable_diag_pkg

/* verilog/cable_diag_result_regs.sv */
// Cable diagnostic result registers with gain control words.
//
// Operation
// - Reserved result bits ignore writes, read zero.
// - Third word: receive peak 1, transmit peak 5.
// - Fourth word: receive peaks 3 and 2.
// - Fifth word: receive peaks 5 and 4.
// - Amplitude halves pair with location register bytes.
// - General word holds ten peak polarities.
// - Bits 5 and 4 flag cross reflections.
// - Bits 3 and 2 flag over five peaks.
// - Four-bit gain control word, default 0011.
// - Twelve-bit fast gain accumulator, reset 0x600.
`timescale 1ns/10ps
`include "cable_diag_cfg.svh"

module cable_diag_result_regs
    import cable_diag_pkg::*;
(
    // Clock, reset and clock enable.
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    // Register access from the management interface.
    input wire reg_req_s req,
    output logic [15:0] rdata_reg,
    output logic rvalid_reg,
    // Reflectometry engine result hand-off.
    input wire logic diag_start,
    input wire logic diag_done,
    input wire diag_result_s diag_result,
    // Analog front-end controls.
    output logic [3:0] gain_amp_setting,
    output logic [11:0] fast_gain_sum
);

    ////////////////////////////////////////////////////////////////////////
    // Decoding helpers.

    // Packs two seven-bit amplitudes into one word, bits 15 and 7 zero.
    function automatic logic [15:0] amp_word(
        input logic [6:0] hi,
        input logic [6:0] lo
    );
        amp_word = {1'b0, hi, 1'b0, lo};
    endfunction : amp_word

    // Builds the general results word from a stored result set.
    function automatic logic [15:0] general_word(input diag_result_s r);
        logic [15:0] w;
        w = `RESULT_RST;
        w[`TX_POL_LSB +: `PEAKS] = r.tx_pol;
        w[`RX_POL_LSB +: `PEAKS] = r.rx_pol;
        w[`TX_CROSS_BIT] = r.tx_cross;
        w[`RX_CROSS_BIT] = r.rx_cross;
        w[`TX_MANY_BIT] = r.tx_many;
        w[`RX_MANY_BIT] = r.rx_many;
        general_word = w;
    endfunction : general_word

    // Selects the read word for an address; unmapped addresses read zero.
    function automatic logic [15:0] read_word(
        input logic [15:0] addr,
        input diag_result_s r,
        input logic [3:0] gain,
        input logic [11:0] acc
    );
        case (addr)
            `AMP3_ADDR: read_word = amp_word(r.rx_amp[0], r.tx_amp5);
            `AMP4_ADDR: read_word = amp_word(r.rx_amp[2], r.rx_amp[1]);
            `AMP5_ADDR: read_word = amp_word(r.rx_amp[4], r.rx_amp[3]);
            `GENERAL_ADDR: read_word = general_word(r);
            `GAIN_ADDR: read_word = {12'h000, gain};
            `ACCUM_ADDR: read_word = {4'h0, acc};
            default: read_word = `RESULT_RST;
        endcase
    endfunction : read_word

    ////////////////////////////////////////////////////////////////////////
    // Result storage.

    diag_result_s res_reg;
    diag_result_s res_next;

    // A new run clears the old results; completion captures the new set.
    // Completion wins when both land in the same cycle so no result is lost.
    always_comb begin
        res_next = res_reg;
        if (diag_done) begin
            res_next = diag_result;
        end else if (diag_start) begin
            res_next = '0;
        end
    end

    // Results only move on start or done and are frozen otherwise.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            res_reg <= '0;
        end else if (ce) begin
            res_reg <= res_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Writable control words.

    logic [3:0] gain_next;
    logic [11:0] acc_next;

    // Only the gain and accumulator fields take writes; all else is dropped.
    always_comb begin
        gain_next = gain_amp_setting;
        acc_next = fast_gain_sum;
        if (req.wr && req.addr == `GAIN_ADDR) begin
            gain_next = req.wdata[3:0];
        end
        if (req.wr && req.addr == `ACCUM_ADDR) begin
            acc_next = req.wdata[11:0];
        end
    end

    // The stored words drive the analog front end directly.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            gain_amp_setting <= `GAIN_RST;
            fast_gain_sum <= `ACCUM_RST;
        end else if (ce) begin
            gain_amp_setting <= gain_next;
            fast_gain_sum <= acc_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path.

    logic [15:0] rdata_next;
    logic rvalid_next;

    // A read returns its word one cycle later; data holds until next read.
    always_comb begin
        rdata_next = rdata_reg;
        rvalid_next = 1'b0;
        if (req.rd) begin
            rdata_next = read_word(req.addr, res_reg, gain_amp_setting,
                fast_gain_sum);
            rvalid_next = 1'b1;
        end
    end

    // Read data register.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= `RESULT_RST;
            rvalid_reg <= 1'b0;
        end else if (ce) begin
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    // Amplitude words keep bit 15 clear whatever was written.
    property p_rsv_zero;
        @(posedge mclk) disable iff (!rst_n)
        ce && req.rd && (req.addr == `AMP3_ADDR || req.addr == `AMP4_ADDR
            || req.addr == `AMP5_ADDR || req.addr == `GENERAL_ADDR)
        |=> rdata_reg[15] == 1'b0 || $past(req.addr) == `GENERAL_ADDR;
    endproperty
    a_rsv_zero: assert property (p_rsv_zero)
        else $error("reserved amplitude bit read as one");

    // Third word places receive peak 1 high and transmit peak 5 low.
    property p_amp3_map;
        @(posedge mclk) disable iff (!rst_n)
        ce && req.rd && req.addr == `AMP3_ADDR |=>
            rdata_reg == {1'b0, $past(res_reg.rx_amp[0]), 1'b0,
                $past(res_reg.tx_amp5)} && rvalid_reg;
    endproperty
    a_amp3_map: assert property (p_amp3_map)
        else $error("third amplitude word has wrong layout");

    // Fourth word places receive peak 3 high and peak 2 low.
    property p_amp4_map;
        @(posedge mclk) disable iff (!rst_n)
        ce && req.rd && req.addr == `AMP4_ADDR |=>
            rdata_reg[14:8] == $past(res_reg.rx_amp[2])
            && rdata_reg[6:0] == $past(res_reg.rx_amp[1]);
    endproperty
    a_amp4_map: assert property (p_amp4_map)
        else $error("fourth amplitude word has wrong layout");

    // Fifth word places receive peak 5 high and peak 4 low.
    property p_amp5_map;
        @(posedge mclk) disable iff (!rst_n)
        ce && req.rd && req.addr == `AMP5_ADDR |=>
            rdata_reg[14:8] == $past(res_reg.rx_amp[4])
            && rdata_reg[6:0] == $past(res_reg.rx_amp[3])
            && rdata_reg[7] == 1'b0;
    endproperty
    a_amp5_map: assert property (p_amp5_map)
        else $error("fifth amplitude word has wrong layout");

    // A completed run followed by a read shows the engine's polarities.
    property p_polarity;
        @(posedge mclk) disable iff (!rst_n)
        ce && diag_done ##1 ce && req.rd && req.addr == `GENERAL_ADDR
            && !diag_done && !diag_start
        |=> rdata_reg[15:11] == $past(diag_result.tx_pol, 2)
            && rdata_reg[10:6] == $past(diag_result.rx_pol, 2);
    endproperty
    a_polarity: assert property (p_polarity)
        else $error("general word polarities do not match the run");

    // Cross reflection flags land at bits 5 and 4, reserved 1:0 stay zero.
    property p_cross;
        @(posedge mclk) disable iff (!rst_n)
        ce && req.rd && req.addr == `GENERAL_ADDR |=>
            rdata_reg[5] == $past(res_reg.tx_cross)
            && rdata_reg[4] == $past(res_reg.rx_cross)
            && rdata_reg[1:0] == 2'b00;
    endproperty
    a_cross: assert property (p_cross)
        else $error("cross reflection flags misplaced");

    // Too-many-peaks flags land at bits 3 and 2.
    property p_many;
        @(posedge mclk) disable iff (!rst_n)
        ce && req.rd && req.addr == `GENERAL_ADDR |=>
            rdata_reg[3] == $past(res_reg.tx_many)
            && rdata_reg[2] == $past(res_reg.rx_many);
    endproperty
    a_many: assert property (p_many)
        else $error("peak count flags misplaced");

    // A gain write reaches the front end next cycle and reads back clean.
    property p_gain_rw;
        @(posedge mclk) disable iff (!rst_n)
        ce && req.wr && req.addr == `GAIN_ADDR ##1 ce && req.rd
            && req.addr == `GAIN_ADDR && !req.wr
        |=> rdata_reg == {12'h000, $past(req.wdata[3:0], 2)}
            && gain_amp_setting == $past(req.wdata[3:0], 2);
    endproperty
    a_gain_rw: assert property (p_gain_rw)
        else $error("gain control word did not take the write");

    // The accumulator never shows bits above 11.
    property p_accum_rsv;
        @(posedge mclk) disable iff (!rst_n)
        ce && req.rd && req.addr == `ACCUM_ADDR |=>
            rdata_reg[15:12] == 4'h0
            && rdata_reg[11:0] == $past(fast_gain_sum);
    endproperty
    a_accum_rsv: assert property (p_accum_rsv)
        else $error("accumulator read is wrong");

    // Without start or done the stored results stay fixed.
    property p_hold;
        @(posedge mclk) disable iff (!rst_n)
        !(ce && (diag_start || diag_done)) |=> $stable(res_reg);
    endproperty
    a_hold: assert property (p_hold)
        else $error("results moved without a run event");

    // The stored receive amplitudes equal the engine's set at completion.
    property p_pairing;
        @(posedge mclk) disable iff (!rst_n)
        ce && diag_done |=> res_reg.rx_amp == $past(diag_result.rx_amp);
    endproperty
    a_pairing: assert property (p_pairing)
        else $error("amplitude not captured with its run");

    // Amplitude words keep both reserved bits clear on every read.
    property p_amp_rsv;
        @(posedge mclk) disable iff (!rst_n)
        ce && req.rd && (req.addr == `AMP3_ADDR || req.addr == `AMP4_ADDR
            || req.addr == `AMP5_ADDR)
        |=> rdata_reg[15] == 1'b0 && rdata_reg[7] == 1'b0 && rvalid_reg;
    endproperty
    a_amp_rsv: assert property (p_amp_rsv)
        else $error("reserved amplitude bits read as one");

    // The gain word reads back in bits 3:0 with the upper bits clear.
    property p_gain_read;
        @(posedge mclk) disable iff (!rst_n)
        ce && req.rd && req.addr == `GAIN_ADDR |=>
            rdata_reg[15:4] == 12'h000
            && rdata_reg[3:0] == $past(gain_amp_setting);
    endproperty
    a_gain_read: assert property (p_gain_read)
        else $error("gain control word read is wrong");

    // A start without done leaves no stale result behind.
    property p_start_clear;
        @(posedge mclk) disable iff (!rst_n)
        ce && diag_start && !diag_done |=> res_reg == '0;
    endproperty
    a_start_clear: assert property (p_start_clear)
        else $error("results not cleared by a new run");

endmodule : cable_diag_result_regs

/* bench/tb_top.sv */
// Self-checking testbench for the cable diagnostic result bank.
`timescale 1ns/10ps
`include "cable_diag_cfg.svh"

module tb_top
    import cable_diag_pkg::*;
;
    // Design ports and bench bookkeeping.
    logic mclk, rst_n, ce, diag_start, diag_done, rvalid_reg;
    reg_req_s req;
    diag_result_s diag_result;
    logic [15:0] rdata_reg;
    logic [3:0] gain_amp_setting;
    logic [11:0] fast_gain_sum;
    int bad_count, check_count;
    int cycles = 0;
    logic [15:0] ad [5];
    logic [15:0] ex [5];

    cable_diag_result_regs dut (.mclk(mclk), .rst_n(rst_n), .ce(ce),
        .req(req), .rdata_reg(rdata_reg), .rvalid_reg(rvalid_reg),
        .diag_start(diag_start), .diag_done(diag_done),
        .diag_result(diag_result), .gain_amp_setting(gain_amp_setting),
        .fast_gain_sum(fast_gain_sum));

    ////////////////////////////////////////////////////////////////////////
    // Clock at 40 MHz and a cycle ceiling that cuts a hang short.
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            bad_count = bad_count + 1;
            $display("CHECK FAILED at %0t: run did not finish", $time);
            end_of_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Compares a 16-bit result and counts it.
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count = check_count + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask : chk

    // One register access taken at the next edge; called at a falling edge.
    task automatic acc(input logic w, input logic r, input logic [15:0] a,
            input logic [15:0] wd, input logic [15:0] exp);
        req.addr = a;
        req.wr = w;
        req.rd = r;
        req.wdata = wd;
        @(negedge mclk);
        chk({15'h0, rvalid_reg}, {15'h0, r});
        if (r) chk(rdata_reg, exp);
    endtask : acc

    // Drops all strobes for one cycle.
    task automatic idle();
        req = '0;
        @(negedge mclk);
    endtask : idle

    // One-cycle pulse on the engine hand-off.
    task automatic pulse(input logic s, input logic d);
        diag_start = s;
        diag_done = d;
        @(negedge mclk);
        diag_start = 1'b0;
        diag_done = 1'b0;
    endtask : pulse

    // Reads the four result words and the unmapped address back to back.
    task automatic read_results();
        for (int i = 0; i < 5; i++) acc(1'b0, 1'b1, ad[i], 16'h0, ex[i]);
        idle();
    endtask : read_results

    ////////////////////////////////////////////////////////////////////////
    // Scenarios.
    task automatic t_reset();
        chk({12'h0, gain_amp_setting}, 16'h0003);
        chk({4'h0, fast_gain_sum}, 16'h0600);
        read_results();
        acc(1'b0, 1'b1, `GAIN_ADDR, 16'h0, 16'h0003);
        acc(1'b0, 1'b1, `ACCUM_ADDR, 16'h0, 16'h0600);
        idle();
    endtask : t_reset

    // A captured set is spread over the words and held after the engine moves.
    task automatic t_capture();
        diag_result.rx_amp = {7'h55, 7'h44, 7'h33, 7'h22, 7'h11};
        diag_result.tx_amp5 = 7'h7f;
        diag_result.tx_pol = 5'h16;
        diag_result.rx_pol = 5'h0d;
        {diag_result.tx_cross, diag_result.rx_cross} = 2'b10;
        {diag_result.tx_many, diag_result.rx_many} = 2'b01;
        pulse(1'b0, 1'b1);
        diag_result = '1;
        acc(1'b0, 1'b1, `GENERAL_ADDR, 16'h0, 16'hb364);
        ex = '{16'h117f, 16'h3322, 16'h5544, 16'hb364, 16'h0};
        read_results();
    endtask : t_capture

    // Writes to result words, reserved bits and an unmapped place change nothing.
    task automatic t_write_ignored();
        for (int i = 0; i < 5; i++) acc(1'b1, 1'b0, ad[i], 16'hffff, 16'h0);
        idle();
        read_results();
    endtask : t_write_ignored

    // Same-cycle read and write of the gain word, then the accumulator.
    task automatic t_gain();
        acc(1'b1, 1'b1, `GAIN_ADDR, 16'hfffa, 16'h0003);
        acc(1'b0, 1'b1, `GAIN_ADDR, 16'h0, 16'h000a);
        chk({12'h0, gain_amp_setting}, 16'h000a);
        acc(1'b1, 1'b0, `ACCUM_ADDR, 16'hfabc, 16'h0);
        acc(1'b0, 1'b1, `ACCUM_ADDR, 16'h0, 16'h0abc);
        chk({4'h0, fast_gain_sum}, 16'h0abc);
        idle();
    endtask : t_gain

    // A new run clears the results; done together with start captures.
    task automatic t_start();
        pulse(1'b1, 1'b0);
        ex = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
        read_results();
        diag_result = '0;
        {diag_result.rx_cross, diag_result.tx_many} = 2'b11;
        pulse(1'b1, 1'b1);
        ex[3] = 16'h0018;
        read_results();
    endtask : t_start

    // With the clock enable low a write is ignored and all state holds.
    task automatic t_freeze();
        ce = 1'b0;
        acc(1'b1, 1'b0, `GAIN_ADDR, 16'h0005, 16'h0);
        chk({12'h0, gain_amp_setting}, 16'h000a);
        ce = 1'b1;
        idle();
        acc(1'b0, 1'b1, `GAIN_ADDR, 16'h0, 16'h000a);
        idle();
    endtask : t_freeze

    // A reset in mid-run restores the defaults and drops stored results.
    task automatic t_mid_reset();
        rst_n = 1'b0;
        @(negedge mclk);
        rst_n = 1'b1;
        chk({12'h0, gain_amp_setting}, 16'h0003);
        chk({4'h0, fast_gain_sum}, 16'h0600);
        acc(1'b0, 1'b1, `GENERAL_ADDR, 16'h0, 16'h0000);
        idle();
    endtask : t_mid_reset

    ////////////////////////////////////////////////////////////////////////
    // Prints the verdict and stops the run.
    task automatic end_of_test();
        if (bad_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test

    // Main sequence: reset for five cycles, then every scenario in turn.
    initial begin
        bad_count = 0;
        check_count = 0;
        rst_n = 1'b0;
        ce = 1'b1;
        req = '0;
        diag_start = 1'b0;
        diag_done = 1'b0;
        diag_result = '0;
        ad = '{`AMP3_ADDR, `AMP4_ADDR, `AMP5_ADDR, `GENERAL_ADDR, 16'h0190};
        ex = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
        repeat (5) @(posedge mclk);
        @(negedge mclk);
        rst_n = 1'b1;
        t_reset();
        t_capture();
        t_write_ignored();
        t_gain();
        t_start();
        t_freeze();
        t_mid_reset();
        end_of_test();
    end
endmodule : tb_top
